// ### design/etr_pkg.sv
// Package: register offsets, field positions and encodings of the timer output block
package etr_pkg;
   localparam int unsigned ETR_AW = 4;
   localparam int unsigned ETR_CW = 10;
   // Register byte offsets
   localparam logic [3:0] ETR_OFF_CTRL1 = 4'h0;
   localparam logic [3:0] ETR_OFF_CTRL2 = 4'h1;
   localparam logic [3:0] ETR_OFF_CNT_LO = 4'h2;
   localparam logic [3:0] ETR_OFF_CNT_HI = 4'h3;
   localparam logic [3:0] ETR_OFF_CMPA_LO = 4'h4;
   localparam logic [3:0] ETR_OFF_CMPA_HI = 4'h5;
   localparam logic [3:0] ETR_OFF_CMPB_LO = 4'h6;
   localparam logic [3:0] ETR_OFF_CMPB_HI = 4'h7;
   // Field positions, first control register
   localparam int unsigned ETR_C1_RUN = 7;
   localparam int unsigned ETR_C1_AMODE = 4;
   // Field positions, second control register
   localparam int unsigned ETR_C2_BMODE = 6;
   localparam int unsigned ETR_C2_BACT = 4;
   localparam int unsigned ETR_C2_BLEVEL = 3;
   localparam int unsigned ETR_C2_BINV = 2;
   localparam int unsigned ETR_C2_ALIGN = 0;
   // Reset values and counter maximum
   localparam logic [7:0] ETR_RST_BYTE = 8'h00;
   localparam logic [9:0] ETR_RST_CNT = 10'h000;
   localparam logic [9:0] ETR_CNT_MAX = 10'h3ff;
   typedef enum logic [1:0] {
      ETR_M_CMP = 2'b00,
      ETR_M_CAP = 2'b01,
      ETR_M_PWM = 2'b10,
      ETR_M_TMR = 2'b11
   } etr_mode_t;
   typedef enum logic [1:0] {
      ETR_AL_EDGE = 2'b00,
      ETR_AL_UP = 2'b01,
      ETR_AL_DOWN = 2'b10,
      ETR_AL_BOTH = 2'b11
   } etr_align_t;
   // Compare-output action codes
   localparam logic [1:0] ETR_ACT_NONE = 2'b00;
   localparam logic [1:0] ETR_ACT_LOW = 2'b01;
   localparam logic [1:0] ETR_ACT_HIGH = 2'b10;
   localparam logic [1:0] ETR_ACT_TOG = 2'b11;
   // PWM action codes
   localparam logic [1:0] ETR_PWM_OFF = 2'b00;
   localparam logic [1:0] ETR_PWM_ON = 2'b01;
   localparam logic [1:0] ETR_PWM_RUN = 2'b10;
   localparam logic [1:0] ETR_PWM_ONE = 2'b11;
endpackage

// ### design/etr_cmp_if.sv
// Interface: counter value and compare match results between top and comparator
`timescale 1ns/1ns
interface etr_cmp_if;
   logic [9:0] count;
   logic [9:0] value;
   logic match;
   logic below;
   modport top (output count, output value, input match, input below);
   modport cmp (input count, input value, output match, output below);
endinterface

// ### design/etr_cmp.sv
// Comparator: one 10-bit compare value against the counter
`timescale 1ns/1ns
module etr_cmp (
   etr_cmp_if.cmp bus
);
   import etr_pkg::*;
   // Full 10-bit compare, both bytes together
   assign bus.match = (bus.count == bus.value);
   assign bus.below = (bus.count < bus.value);
endmodule

// ### design/etr_top.sv
// Timer output-B channel: control, compare and counter registers, pin B logic
// ===========================================================================
`timescale 1ns/1ns
module etr_top (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [etr_pkg::ETR_AW-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic output_pin_b,
   output logic output_pin_b_oe,
   output logic match_a,
   output logic match_b
);
   import etr_pkg::*;

   // ========================================================================
   // Registers
   logic [7:0] first_control_reg_r;
   logic [7:0] second_control_reg_r;
   logic [7:0] compare_a_low_byte_r;
   logic [1:0] compare_a_high_bits_r;
   logic [7:0] compare_b_low_byte_r;
   logic [1:0] compare_b_high_bits_r;
   logic [9:0] count_r;
   logic [9:0] count_nxt;
   logic dir_down_r;
   logic run_d_r;
   logic pin_r;
   logic pin_nxt;
   logic pulse_done_r;
   logic match_a_r;
   logic match_b_r;
   logic [7:0] rdata_r;

   // ========================================================================
   // Field decode
   wire counter_run = first_control_reg_r[ETR_C1_RUN];
   wire channel_a_mode_hi = first_control_reg_r[ETR_C1_AMODE+1];
   wire channel_a_mode_lo = first_control_reg_r[ETR_C1_AMODE];
   wire channel_b_mode_hi = second_control_reg_r[ETR_C2_BMODE+1];
   wire channel_b_mode_lo = second_control_reg_r[ETR_C2_BMODE];
   wire [1:0] b_action = second_control_reg_r[ETR_C2_BACT+:2];
   wire output_b_level = second_control_reg_r[ETR_C2_BLEVEL];
   wire output_b_invert = second_control_reg_r[ETR_C2_BINV];
   wire [1:0] pwm_alignment_select = second_control_reg_r[ETR_C2_ALIGN+:2];

   // Mode of each channel comes from its own field
   etr_mode_t mode_a;
   etr_mode_t mode_b;
   assign mode_a = etr_mode_t'({channel_a_mode_hi, channel_a_mode_lo});
   assign mode_b = etr_mode_t'({channel_b_mode_hi, channel_b_mode_lo});
   // Single pulse needs both channels in PWM-class with action one-shot;
   // pairing legality is left to software, nothing here corrects it
   wire b_is_pwm = (mode_b == ETR_M_PWM);
   wire single_pulse = b_is_pwm && (mode_a == ETR_M_PWM)
                       && (b_action == ETR_PWM_ONE);
   wire b_is_cmp = (mode_b == ETR_M_CMP);
   wire b_is_tmr = (mode_b == ETR_M_TMR);
   wire b_is_cap = (mode_b == ETR_M_CAP);
   wire run_rise = counter_run && !run_d_r;
   etr_align_t align;
   assign align = etr_align_t'(pwm_alignment_select);
   wire centre = (align != ETR_AL_EDGE);

   // Compare values as full 10-bit words
   wire [9:0] compare_a_value = {compare_a_high_bits_r, compare_a_low_byte_r};
   wire [9:0] compare_b_value = {compare_b_high_bits_r, compare_b_low_byte_r};

   // ========================================================================
   // Comparators
   etr_cmp_if cmp_a_if ();
   etr_cmp_if cmp_b_if ();
   assign cmp_a_if.count = count_r;
   assign cmp_a_if.value = compare_a_value;
   assign cmp_b_if.count = count_r;
   assign cmp_b_if.value = compare_b_value;
   etr_cmp u_cmp_a (
      .bus(cmp_a_if)
   );
   etr_cmp u_cmp_b (
      .bus(cmp_b_if)
   );
   wire hit_a = cmp_a_if.match && counter_run;
   wire hit_b_raw = cmp_b_if.match && counter_run;

   // Centre-up and centre-down modes qualify the B match by count direction; both-edge centre mode does not
   logic hit_b;
   always_comb begin
      case (align)
         ETR_AL_EDGE: hit_b = hit_b_raw;
         ETR_AL_UP: hit_b = hit_b_raw && !dir_down_r;
         ETR_AL_DOWN: hit_b = hit_b_raw && dir_down_r;
         ETR_AL_BOTH: hit_b = hit_b_raw;
         default: hit_b = hit_b_raw;
      endcase
   end

   // ========================================================================
   // Counter: edge counts up and wraps; centre counts up then down.
   // Period control by other comparators lives outside this block.
   wire at_top = (count_r == ETR_CNT_MAX);
   wire at_bot = (count_r == ETR_RST_CNT);
   wire turn_down = centre && !dir_down_r && at_top;
   wire turn_up = centre && dir_down_r && at_bot;
   always_comb begin
      count_nxt = count_r;
      if (run_rise) begin
         count_nxt = ETR_RST_CNT;
      end else if (counter_run) begin
         if (turn_down || (dir_down_r && !turn_up)) begin
            count_nxt = count_r - 10'h001;
         end else begin
            count_nxt = count_r + 10'h001;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         count_r <= ETR_RST_CNT;
         dir_down_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         if (run_rise || !centre) begin
            dir_down_r <= 1'b0;
         end else if (turn_down) begin
            dir_down_r <= 1'b1;
         end else if (turn_up) begin
            dir_down_r <= 1'b0;
         end
      end
   end

   // ========================================================================
   // Pin B raw state (before polarity)
   // PWM active while count below compare B; level bit picks active sense
   wire pwm_active = cmp_b_if.below;
   wire pwm_level = pwm_active ? output_b_level : !output_b_level;
   always_comb begin
      pin_nxt = pin_r;
      if (run_rise && (b_is_cmp || b_is_pwm)) begin
         // Counter start restores the configured initial level; timer and
         // capture leave the pin alone, the level bit means nothing there
         pin_nxt = output_b_level;
      end else if (b_is_cmp) begin
         // Level bit holds until the first B match
         if (hit_b) begin
            case (b_action)
               ETR_ACT_NONE: pin_nxt = pin_r;
               ETR_ACT_LOW: pin_nxt = 1'b0;
               ETR_ACT_HIGH: pin_nxt = 1'b1;
               ETR_ACT_TOG: pin_nxt = !pin_r;
               default: pin_nxt = pin_r;
            endcase
         end else if (!counter_run) begin
            pin_nxt = output_b_level;
         end
      end else if (b_is_pwm) begin
         case (b_action)
            ETR_PWM_OFF: pin_nxt = !output_b_level;
            ETR_PWM_ON: pin_nxt = output_b_level;
            ETR_PWM_RUN: pin_nxt = counter_run ? pwm_level : !output_b_level;
            ETR_PWM_ONE: pin_nxt = (counter_run && !pulse_done_r)
                                   ? output_b_level : !output_b_level;
            default: pin_nxt = pin_r;
         endcase
      end else begin
         // Timer/counter and capture ignore the level bit
         pin_nxt = pin_r;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_r <= 1'b0;
         run_d_r <= 1'b0;
         pulse_done_r <= 1'b0;
      end else begin
         pin_r <= pin_nxt;
         run_d_r <= counter_run;
         // One shot ends on the B match, rearmed by a new start
         if (run_rise) begin
            pulse_done_r <= 1'b0;
         end else if (single_pulse && hit_b) begin
            pulse_done_r <= 1'b1;
         end
      end
   end

   // Polarity applies everywhere except timer/counter mode, input capture included
   wire pin_drive = b_is_cmp || b_is_pwm;
   wire pin_inv = output_b_invert && !b_is_tmr;
   assign output_pin_b = pin_r ^ pin_inv;
   // Pin released to normal I/O in timer/counter mode, and input in capture
   assign output_pin_b_oe = pin_drive && !b_is_cap;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         match_a_r <= 1'b0;
         match_b_r <= 1'b0;
      end else begin
         match_a_r <= hit_a;
         match_b_r <= hit_b;
      end
   end
   assign match_a = match_a_r;
   assign match_b = match_b_r;

   // ========================================================================
   // Register writes
   wire wr_c1 = wr && (addr == ETR_OFF_CTRL1);
   wire wr_c2 = wr && (addr == ETR_OFF_CTRL2);
   wire wr_al = wr && (addr == ETR_OFF_CMPA_LO);
   wire wr_ah = wr && (addr == ETR_OFF_CMPA_HI);
   wire wr_bl = wr && (addr == ETR_OFF_CMPB_LO);
   wire wr_bh = wr && (addr == ETR_OFF_CMPB_HI);
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         first_control_reg_r <= ETR_RST_BYTE;
         second_control_reg_r <= ETR_RST_BYTE;
         compare_a_low_byte_r <= ETR_RST_BYTE;
         compare_a_high_bits_r <= 2'b00;
         compare_b_low_byte_r <= ETR_RST_BYTE;
         compare_b_high_bits_r <= 2'b00;
      end else begin
         if (wr_c1) first_control_reg_r <= wdata;
         if (wr_c2) second_control_reg_r <= wdata;
         if (wr_al) compare_a_low_byte_r <= wdata;
         if (wr_ah) compare_a_high_bits_r <= wdata[1:0];
         if (wr_bl) compare_b_low_byte_r <= wdata;
         if (wr_bh) compare_b_high_bits_r <= wdata[1:0];
      end
   end

   // ========================================================================
   // Register reads, data one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      case (addr)
         ETR_OFF_CTRL1: rd_mux = first_control_reg_r;
         ETR_OFF_CTRL2: rd_mux = second_control_reg_r;
         ETR_OFF_CNT_LO: rd_mux = count_r[7:0];
         ETR_OFF_CNT_HI: rd_mux = {6'b00_0000, count_r[9:8]};
         ETR_OFF_CMPA_LO: rd_mux = compare_a_low_byte_r;
         ETR_OFF_CMPA_HI: rd_mux = {6'b00_0000, compare_a_high_bits_r};
         ETR_OFF_CMPB_LO: rd_mux = compare_b_low_byte_r;
         ETR_OFF_CMPB_HI: rd_mux = {6'b00_0000, compare_b_high_bits_r};
         default: rd_mux = ETR_RST_BYTE;
      endcase
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= ETR_RST_BYTE;
      end else begin
         // Zero outside the answer cycle keeps the bus quiet
         rdata_r <= rd ? rd_mux : ETR_RST_BYTE;
      end
   end
   assign rdata = rdata_r;

endmodule

// ### bench/etr_top_props.sv
// Checker: port-level properties of the timer output-B block
`timescale 1ns/1ns
module etr_top_props (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [etr_pkg::ETR_AW-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic output_pin_b,
   input wire logic output_pin_b_oe,
   input wire logic match_a,
   input wire logic match_b
);
   import etr_pkg::*;
   // ==========================================
   // Shadow of the two control registers
   logic [7:0] c1_r;
   logic [7:0] c2_r;
   wire wr_c1 = wr && addr == ETR_OFF_CTRL1;
   wire wr_c2 = wr && addr == ETR_OFF_CTRL2;
   wire b_cmp = c2_r[7:6] == ETR_M_CMP;
   wire b_tmr = c2_r[7:6] == ETR_M_TMR;
   wire lvl_pin = c2_r[3] ^ c2_r[2];
   wire hi_addr = addr == ETR_OFF_CNT_HI || addr == ETR_OFF_CMPA_HI || addr == ETR_OFF_CMPB_HI;
   wire inv_only = (wdata ^ c2_r) == 8'h04 && wdata[7:6] == ETR_M_TMR;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         c1_r <= 8'h00;
         c2_r <= 8'h00;
      end else begin
         c1_r <= wr_c1 ? wdata : c1_r;
         c2_r <= wr_c2 ? wdata : c2_r;
      end
   end
   // ==========================================
   // Properties
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_wr_rd(a);
      wr && addr == a ##2 rd && addr == a;
   endsequence
   // Pin register lags the control write by one cycle, so wait three
   sequence s_quiet;
      (!c1_r[7] && b_cmp && $stable(c2_r)) [*3];
   endsequence
   property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata set without read");
   property p_hi_zero; rd && hi_addr |=> rdata[7:2] == 6'h00; endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("high byte upper bits set");
   property p_unmap; rd && addr[3] |=> rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_cmpa;
      s_wr_rd(ETR_OFF_CMPA_LO) |=> rdata == $past(wdata, 3);
   endproperty
   a_cmpa: assert property (p_cmpa) else $error("compare A low readback wrong");
   property p_cmpb;
      s_wr_rd(ETR_OFF_CMPB_HI) |=> rdata == ($past(wdata, 3) & 8'h03);
   endproperty
   a_cmpb: assert property (p_cmpb) else $error("compare B high readback wrong");
   property p_oe; output_pin_b_oe == (b_cmp || c2_r[7:6] == ETR_M_PWM); endproperty
   a_oe: assert property (p_oe) else $error("pin enable does not follow mode");
   property p_pin_idle; s_quiet |-> output_pin_b == lvl_pin; endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("idle pin level wrong");
   property p_run; $rose(c1_r[7]) && b_cmp |-> ##[0:2] output_pin_b == lvl_pin; endproperty
   a_run: assert property (p_run) else $error("run start did not set level");
   property p_inv_tmr;
      wr_c2 && b_tmr && inv_only && !c1_r[7] |=> $stable(output_pin_b) [*2];
   endproperty
   a_inv_tmr: assert property (p_inv_tmr) else $error("invert acted in timer mode");
   property p_match_idle; !c1_r[7] |=> !match_a && !match_b; endproperty
   a_match_idle: assert property (p_match_idle) else $error("stray match");
endmodule
bind etr_top etr_top_props u_props (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .output_pin_b(output_pin_b),
   .output_pin_b_oe(output_pin_b_oe), .match_a(match_a), .match_b(match_b));

// ### bench/tb.sv
// Testbench: register, pin and alignment scenarios for the timer output-B block
`timescale 1ns/1ns
module tb;
   import etr_pkg::*;
   logic mclk;
   logic nrst;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic pin_b;
   logic pin_oe;
   logic ma;
   logic mb;
   int miscompares = 0;
   int compares = 0;
   etr_top dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .output_pin_b(pin_b), .output_pin_b_oe(pin_oe), .match_a(ma),
      .match_b(mb));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ==========================================
   // Bus and compare helpers
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(n, e, rdata);
   endtask
   task automatic pin_chk(input string n, input int c, input logic e);
      repeat (c) @(posedge mclk);
      @(negedge mclk);
      chk(n, e, pin_b);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      chk("oe at reset", 1'b1, pin_oe);
      for (int i = 0; i < 9; i++) rd_chk("reset value", 4'(i), 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_regs();
      wr_reg(ETR_OFF_CNT_LO, 8'hff);
      wr_reg(4'h9, 8'hff);
      wr_reg(ETR_OFF_CMPA_HI, 8'hff);
      rd_chk("cmpa hi", ETR_OFF_CMPA_HI, 8'h03);
      wr_reg(ETR_OFF_CMPA_LO, 8'h3c);
      rd_chk("cmpa lo", ETR_OFF_CMPA_LO, 8'h3c);
      wr_reg(ETR_OFF_CMPB_HI, 8'hfe);
      rd_chk("cmpb hi", ETR_OFF_CMPB_HI, 8'h02);
      rd_chk("cnt lo", ETR_OFF_CNT_LO, 8'h00);
      rd_chk("unmapped", 4'h9, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_pin();
      logic p;
      for (int i = 0; i < 4; i++) begin
         wr_reg(ETR_OFF_CTRL2, 8'(i << 2));
         pin_chk("idle pin", 3, i[1] ^ i[0]);
      end
      wr_reg(ETR_OFF_CTRL2, 8'hc0);
      // Timer keeps the level 1 left by the last compare setting
      pin_chk("timer pin", 3, 1'b1);
      p = 1'b1;
      chk("timer oe", 1'b0, pin_oe);
      wr_reg(ETR_OFF_CTRL2, 8'hc4);
      pin_chk("timer invert", 3, p);
      wr_reg(ETR_OFF_CTRL2, 8'hcc);
      pin_chk("timer level", 3, p);
      wr_reg(ETR_OFF_CTRL2, 8'hc0);
      wr_reg(ETR_OFF_CTRL1, 8'h80);
      pin_chk("timer run", 3, p);
      wr_reg(ETR_OFF_CTRL1, 8'h00);
      wr_reg(ETR_OFF_CTRL2, 8'h40);
      pin_chk("capture pin", 1, p);
      chk("capture oe", 1'b0, pin_oe);
      $display("t_pin done");
   endtask
   task automatic t_cmp_run();
      wr_reg(ETR_OFF_CMPB_LO, 8'h05);
      wr_reg(ETR_OFF_CMPB_HI, 8'h00);
      wr_reg(ETR_OFF_CTRL2, 8'h30);
      wr_reg(ETR_OFF_CTRL1, 8'h80);
      pin_chk("before match", 1, 1'b0);
      pin_chk("after toggle", 15, 1'b1);
      wr_reg(ETR_OFF_CTRL1, 8'h00);
      wr_reg(ETR_OFF_CTRL1, 8'h80);
      pin_chk("restart level", 2, 1'b0);
      // Toggle after five counts proves the counter restarted from zero
      pin_chk("restart toggle", 5, 1'b1);
      $display("t_cmp_run done");
   endtask
   task automatic t_pwm();
      for (int i = 0; i < 4; i++) begin
         wr_reg(ETR_OFF_CTRL1, 8'h00);
         wr_reg(ETR_OFF_CMPB_LO, 8'h00);
         wr_reg(ETR_OFF_CMPB_HI, 8'h01);
         wr_reg(ETR_OFF_CTRL2, 8'ha0 | 8'(i << 2));
         wr_reg(ETR_OFF_CTRL1, 8'h80); // A compare beside B PWM
         pin_chk("pwm active", 4, i[1] ^ i[0]);
         wr_reg(ETR_OFF_CMPB_HI, 8'h00);
         pin_chk("pwm inactive", 4, ~(i[1] ^ i[0]));
      end
      $display("t_pwm done");
   endtask
   task automatic t_pulse();
      wr_reg(ETR_OFF_CTRL1, 8'h00);
      wr_reg(ETR_OFF_CMPB_LO, 8'h05);
      wr_reg(ETR_OFF_CMPB_HI, 8'h00);
      wr_reg(ETR_OFF_CTRL2, 8'hb8);
      pin_chk("pulse armed", 1, 1'b0);
      // Both channels enter single pulse together with the start
      wr_reg(ETR_OFF_CTRL1, 8'ha0);
      pin_chk("pulse on", 3, 1'b1);
      pin_chk("pulse end", 6, 1'b0);
      wr_reg(ETR_OFF_CTRL1, 8'h00);
      $display("t_pulse done");
   endtask
   task automatic t_align();
      int n;
      int na;
      logic [9:0] exp_n [4] = '{10'h002, 10'h001, 10'h001, 10'h002};
      for (int al = 0; al < 4; al++) begin
         n = 0;
         na = 0;
         wr_reg(ETR_OFF_CTRL1, 8'h00);
         wr_reg(ETR_OFF_CMPB_LO, 8'h64);
         wr_reg(ETR_OFF_CTRL2, 8'ha8 | 8'(al));
         wr_reg(ETR_OFF_CTRL1, 8'h80);
         // Window of 2040 cycles falls just short of one centre period (2046) and of two edge periods (2048)
         repeat (2040) begin
            @(negedge mclk);
            if (mb === 1'b1) n++;
            if (ma === 1'b1) na++;
         end
         chk("match_b count", exp_n[al], 10'(n));
         // Compare A is 0x33c: passed once up, once down or once per edge period
         chk("match_a count", 10'h002, 10'(na));
         rd_chk("cnt hi", ETR_OFF_CNT_HI, (al == 0) ? 8'h03 : 8'h00);
      end
      wr_reg(ETR_OFF_CTRL1, 8'h00);
      $display("t_align done");
   endtask
   // ==========================================
   // Sequence and verdict
   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_regs();
      t_pin();
      t_cmp_run();
      t_pwm();
      t_pulse();
      t_align();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      $display("watchdog expired");
      close_out();
   end
endmodule
